// file: design/uhp_bridge.sv
// UART host port: I2C or SPI slave to a small register set, a TX FIFO
// feeding an 8N1 transmitter, an RX FIFO fed from a user port, and
// automatic RS-485 direction output.
// Assumes scl/sda/spi inputs are already synchronous to mclk.
// Behaviour
// - SPI mode drives SO while chip select is low, tristated otherwise.
// - Receive direction after last stop bit.
// - Transmit direction when byte loaded into transmitter.
// - Auto direction off at reset, enable bit4.
// - Direction high receive, low transmit by default.
// - Control bit5 inverts direction polarity.
// - Oversampling of 16, 8 or 4.
// - Prescaler divides input clock by 1 or 4.
// - Separate 64-byte transmit and receive FIFOs.
// - Select pin picks I2C or SPI host port.
// - Start then address byte decoded by slave.
// - Sub-address byte selects internal register.
// - Ack each written byte, data low.
// - Full transmit FIFO write gets a nack.
// - Works at 100 and 400 kbps.
// - Sub-address register 6:3, channel 2:1 zero.
// - Address bit0 zero write, one read.
// - Two straps choose one of eight addresses.
`timescale 1ns/100ps
module uhp_bridge #(
	parameter int FIFO_DEPTH = uhp_pkg::FIFO_DEPTH
) (
	input wire logic mclk, // 125 MHz clock.
	input wire logic sys_rst, // Synchronous reset, high.
	input wire logic clk_en, // Freezes all state when low.
	input wire logic i2c_sel, // High selects I2C, low SPI.
	input wire logic [1:0] addr_strap_hi, // Strap code 0..3.
	input wire logic [1:0] addr_strap_lo, // Strap code 0..3.
	input wire logic scl_in, // Serial clock from host.
	input wire logic sda_in, // I2C data line level.
	output logic sda_out, // I2C data driven value.
	output logic sda_oe_n, // Low pulls data line.
	input wire logic spi_cs_n, // SPI chip select, low.
	input wire logic spi_si, // SPI data in.
	output logic spi_so, // SPI data out.
	output logic spi_so_oe_n, // Low drives SO.
	output logic txd, // UART serial output.
	output logic rts_n, // RS-485 direction output.
	input wire logic [7:0] rx_data, // Received byte.
	input wire logic rx_valid, // Received byte valid.
	output logic rx_ready // RX FIFO can take a byte.
);
	uhp_pkg::uhp_i2c_st_t st_q;
	uhp_pkg::uhp_i2c_st_t nxt_q;
	logic scl_q, sda_q;
	logic din, scl_rise, scl_fall, start_c, stop_c, byte_done;
	logic [7:0] sh_q, so_sh_q, spi_byte, rd_val, wr_dat;
	logic [3:0] cnt_q, reg_q, rd_sel;
	logic rw_q, first_q, mack_q, ch_ok_q, spi_done;
	logic wr_go, rd_go, wr_ok;
	logic [6:0] my_addr_q;
	logic [15:0] div_q;
	logic [7:0] mode_q, extra_feature_control_reg_q;
	logic tx_in_ready, tx_out_valid, tx_pop;
	logic [7:0] tx_out_data;
	logic rx_out_valid, rx_pop;
	logic [7:0] rx_out_data;
	logic [1:0] pre_q, pre_lim;
	logic [15:0] dcnt_q;
	logic [4:0] ocnt_q, ovs_n;
	logic smp_tick, bit_tick;
	logic busy_q, dir_rx_q;
	logic [3:0] bit_q;
	logic [7:0] tsh_q;

	// Bit 2 of the address from the high strap, bits 1:0 from the low.
	function automatic logic [6:0] strap_addr(input logic [1:0] hi,
			input logic [1:0] lo);
		logic hb;
		hb = (hi == uhp_pkg::STRAP_GND) || (hi == uhp_pkg::STRAP_SDA);
		strap_addr = uhp_pkg::I2C_BASE | {4'h0, hb, lo};
	endfunction

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			my_addr_q <= strap_addr(addr_strap_hi, addr_strap_lo);
		end
	end

	assign din = i2c_sel ? sda_in : spi_si;
	assign scl_rise = scl_in && !scl_q;
	assign scl_fall = !scl_in && scl_q;
	assign start_c = scl_in && scl_q && sda_q && !sda_in;
	assign stop_c = scl_in && scl_q && !sda_q && sda_in;
	assign byte_done = scl_fall && (cnt_q == uhp_pkg::BYTE_BITS);
	assign spi_byte = {sh_q[6:0], din};
	assign spi_done = !spi_cs_n && scl_rise &&
		(cnt_q[2:0] == uhp_pkg::SPI_LAST);
	assign sda_out = 1'b0;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (clk_en) begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// Register strobes shared by both host ports.
	always_comb begin
		wr_go = 1'b0;
		rd_go = 1'b0;
		wr_dat = sh_q;
		rd_sel = reg_q;
		if (i2c_sel) begin
			wr_go = (st_q == uhp_pkg::ST_WR) && byte_done && ch_ok_q;
			rd_go = scl_fall && (((st_q == uhp_pkg::ST_ACK) &&
				(nxt_q == uhp_pkg::ST_RD)) ||
				((st_q == uhp_pkg::ST_RACK) && !mack_q));
		end else begin
			wr_dat = spi_byte;
			wr_go = spi_done && !first_q && !rw_q && ch_ok_q;
			rd_go = spi_done && (first_q ? spi_byte[uhp_pkg::SPI_RD_BIT]
				: rw_q);
			if (first_q) begin
				rd_sel = spi_byte[uhp_pkg::SUB_REG_HI:uhp_pkg::SUB_REG_LO];
			end
		end
	end

	assign wr_ok = !((reg_q == uhp_pkg::REG_DATA) && !tx_in_ready);
	assign rx_pop = rd_go && (rd_sel == uhp_pkg::REG_DATA);

	always_comb begin
		unique case (rd_sel)
			uhp_pkg::REG_DATA: rd_val = rx_out_valid ? rx_out_data : 8'h00;
			uhp_pkg::REG_DIV_LO: rd_val = div_q[7:0];
			uhp_pkg::REG_DIV_HI: rd_val = div_q[15:8];
			uhp_pkg::REG_MODE: rd_val = mode_q;
			uhp_pkg::REG_STAT: rd_val = {3'h0, dir_rx_q, busy_q,
				rx_out_valid, !tx_in_ready, !tx_out_valid};
			uhp_pkg::REG_EXTRA_FEATURE_CONTROL_REG: rd_val = extra_feature_control_reg_q;
			default: rd_val = 8'h00;
		endcase
	end

	// Host port sequencing; only the selected port's branch runs.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= uhp_pkg::ST_IDLE;
			nxt_q <= uhp_pkg::ST_IDLE;
			sh_q <= 8'h00;
			so_sh_q <= 8'h00;
			cnt_q <= 4'h0;
			reg_q <= 4'h0;
			rw_q <= 1'b0;
			first_q <= 1'b1;
			mack_q <= 1'b1;
			ch_ok_q <= 1'b0;
			sda_oe_n <= 1'b1;
			spi_so <= 1'b0;
			spi_so_oe_n <= 1'b1;
		end else if (clk_en) begin
			spi_so_oe_n <= i2c_sel || spi_cs_n;
			if (!i2c_sel) begin
				sda_oe_n <= 1'b1;
				st_q <= uhp_pkg::ST_IDLE;
				if (spi_cs_n) begin
					cnt_q <= 4'h0;
					first_q <= 1'b1;
				end else if (scl_rise) begin
					sh_q <= spi_byte;
					cnt_q <= {1'b0, cnt_q[2:0] + 3'h1};
					if (spi_done && first_q) begin
						first_q <= 1'b0;
						rw_q <= spi_byte[uhp_pkg::SPI_RD_BIT];
						reg_q <= rd_sel;
						ch_ok_q <= spi_byte[uhp_pkg::SUB_CH_HI:
							uhp_pkg::SUB_CH_LO] == uhp_pkg::CH_VALID;
					end
					if (rd_go) begin
						so_sh_q <= rd_val;
					end
				end else if (scl_fall) begin
					spi_so <= so_sh_q[7];
					so_sh_q <= {so_sh_q[6:0], 1'b0};
				end
			end else if (start_c) begin
				st_q <= uhp_pkg::ST_ADDR;
				cnt_q <= 4'h0;
				sda_oe_n <= 1'b1;
			end else if (stop_c) begin
				st_q <= uhp_pkg::ST_IDLE;
				sda_oe_n <= 1'b1;
			end else begin
				unique case (st_q)
					uhp_pkg::ST_ADDR, uhp_pkg::ST_SUB, uhp_pkg::ST_WR: begin
						if (scl_rise) begin
							sh_q <= {sh_q[6:0], din};
							cnt_q <= cnt_q + 4'h1;
						end else if (byte_done) begin
							cnt_q <= 4'h0;
							st_q <= uhp_pkg::ST_ACK;
							nxt_q <= uhp_pkg::ST_WR;
							sda_oe_n <= 1'b0;
							if (st_q == uhp_pkg::ST_ADDR) begin
								rw_q <= sh_q[0];
								nxt_q <= sh_q[0] ? uhp_pkg::ST_RD
									: uhp_pkg::ST_SUB;
								if (sh_q[7:1] != my_addr_q) begin
									st_q <= uhp_pkg::ST_IDLE;
									sda_oe_n <= 1'b1;
								end
							end else if (st_q == uhp_pkg::ST_SUB) begin
								reg_q <= sh_q[uhp_pkg::SUB_REG_HI:
									uhp_pkg::SUB_REG_LO];
								ch_ok_q <= sh_q[uhp_pkg::SUB_CH_HI:
									uhp_pkg::SUB_CH_LO] == uhp_pkg::CH_VALID;
								if (sh_q[uhp_pkg::SUB_CH_HI:uhp_pkg::SUB_CH_LO]
										!= uhp_pkg::CH_VALID) begin
									sda_oe_n <= 1'b1;
									nxt_q <= uhp_pkg::ST_IDLE;
								end
							end else begin
								sda_oe_n <= !(wr_ok && ch_ok_q);
							end
						end
					end
					uhp_pkg::ST_ACK: begin
						if (scl_fall) begin
							sda_oe_n <= 1'b1;
							st_q <= nxt_q;
							cnt_q <= 4'h0;
							if (nxt_q == uhp_pkg::ST_RD) begin
								sh_q <= {rd_val[6:0], 1'b0};
								sda_oe_n <= rd_val[7];
								cnt_q <= 4'h1;
							end
						end
					end
					uhp_pkg::ST_RD: begin
						if (scl_fall) begin
							if (cnt_q == uhp_pkg::BYTE_BITS) begin
								sda_oe_n <= 1'b1;
								st_q <= uhp_pkg::ST_RACK;
							end else begin
								sda_oe_n <= sh_q[7];
								sh_q <= {sh_q[6:0], 1'b0};
								cnt_q <= cnt_q + 4'h1;
							end
						end
					end
					uhp_pkg::ST_RACK: begin
						if (scl_rise) begin
							mack_q <= din;
						end else if (scl_fall) begin
							if (!mack_q) begin
								sh_q <= {rd_val[6:0], 1'b0};
								sda_oe_n <= rd_val[7];
								cnt_q <= 4'h1;
								st_q <= uhp_pkg::ST_RD;
							end else begin
								st_q <= uhp_pkg::ST_IDLE;
							end
						end
					end
					uhp_pkg::ST_IDLE: begin
						sda_oe_n <= 1'b1;
					end
				endcase
			end
		end
	end

	// Software-visible control; a zero divisor behaves as one.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			div_q <= uhp_pkg::DIV_RST;
			mode_q <= uhp_pkg::MODE_RST;
			extra_feature_control_reg_q <= uhp_pkg::EXTRA_FEATURE_CONTROL_REG_RST;
		end else if (clk_en && wr_go) begin
			unique case (reg_q)
				uhp_pkg::REG_DIV_LO: div_q[7:0] <= wr_dat;
				uhp_pkg::REG_DIV_HI: div_q[15:8] <= wr_dat;
				uhp_pkg::REG_MODE: mode_q <= wr_dat;
				uhp_pkg::REG_EXTRA_FEATURE_CONTROL_REG: extra_feature_control_reg_q <= wr_dat;
				default: ;
			endcase
		end
	end

	uhp_fifo #(.W(uhp_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.in_valid(wr_go && (reg_q == uhp_pkg::REG_DATA)),
		.in_ready(tx_in_ready),
		.in_data(wr_dat),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_out_data)
	);

	uhp_fifo #(.W(uhp_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.in_data(rx_data),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_out_data)
	);

	// Baud generation: prescaler, integer divisor, then oversampling.
	assign pre_lim = mode_q[uhp_pkg::MODE_PRE4] ? uhp_pkg::PRE_LIM_4
		: uhp_pkg::PRE_LIM_1;
	always_comb begin
		unique case (mode_q[uhp_pkg::MODE_OVS_HI:uhp_pkg::MODE_OVS_LO])
			uhp_pkg::OVS_SEL_8: ovs_n = uhp_pkg::OVS_8;
			uhp_pkg::OVS_SEL_4: ovs_n = uhp_pkg::OVS_4;
			default: ovs_n = uhp_pkg::OVS_16;
		endcase
	end
	assign smp_tick = (pre_q == pre_lim) &&
		((dcnt_q + 16'h1) >= div_q);
	assign bit_tick = smp_tick && ((ocnt_q + 5'h1) >= ovs_n);
	assign tx_pop = !busy_q;

	always_ff @(posedge mclk) begin
		if (sys_rst || !busy_q) begin
			pre_q <= 2'h0;
			dcnt_q <= 16'h0;
			ocnt_q <= 5'h0;
		end else if (clk_en) begin
			pre_q <= (pre_q == pre_lim) ? 2'h0 : pre_q + 2'h1;
			if (pre_q == pre_lim) begin
				dcnt_q <= smp_tick ? 16'h0 : dcnt_q + 16'h1;
			end
			if (smp_tick) begin
				ocnt_q <= bit_tick ? 5'h0 : ocnt_q + 5'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			bit_q <= 4'h0;
			tsh_q <= 8'h00;
			txd <= 1'b1;
		end else if (clk_en) begin
			if (!busy_q) begin
				if (tx_out_valid) begin
					busy_q <= 1'b1;
					tsh_q <= tx_out_data;
					bit_q <= 4'h0;
					txd <= 1'b0;
				end
			end else if (bit_tick) begin
				if (bit_q == uhp_pkg::FRAME_LAST) begin
					busy_q <= 1'b0;
				end else begin
					txd <= (bit_q == uhp_pkg::BYTE_BITS) ? 1'b1 : tsh_q[0];
					tsh_q <= {1'b0, tsh_q[7:1]};
					bit_q <= bit_q + 4'h1;
				end
			end
		end
	end

	// Direction follows the transmitter, not the FIFO, so back-to-back
	// bytes keep the line turned toward transmit.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dir_rx_q <= 1'b1;
			rts_n <= 1'b1;
		end else if (clk_en) begin
			if (!busy_q && tx_out_valid) begin
				dir_rx_q <= 1'b0;
			end else if (!busy_q) begin
				dir_rx_q <= 1'b1;
			end
			rts_n <= extra_feature_control_reg_q[uhp_pkg::EXTRA_FEATURE_CONTROL_REG_AUTO_DIR] ?
				(dir_rx_q ^ extra_feature_control_reg_q[uhp_pkg::EXTRA_FEATURE_CONTROL_REG_DIR_INV]) : 1'b1;
		end
	end
endmodule // uhp_bridge

// file: design/uhp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; clk_en low freezes every pointer.
`timescale 1ns/100ps
module uhp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 64
) (
	input wire logic mclk, // Clock.
	input wire logic sys_rst, // Synchronous reset, high.
	input wire logic clk_en, // Freezes state when low.
	input wire logic in_valid, // Write request.
	output logic in_ready, // Not full.
	input wire logic [W-1:0] in_data, // Write data.
	output logic out_valid, // Not empty.
	input wire logic out_ready, // Read accept.
	output logic [W-1:0] out_data // Head word.
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	logic push;
	logic pop;

	assign in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
	assign out_valid = wp_q != rp_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rp_q[AW-1:0]];

	always_ff @(posedge mclk) begin
		if (clk_en && push) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wp_q <= '0;
			rp_q <= '0;
		end else if (clk_en) begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule // uhp_fifo

// file: design/uhp_pkg.sv
// Constants shared by the UART host port and its FIFO.
// Assumes a single mclk domain; nothing here holds logic.
package uhp_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 64;
	// Internal register numbers carried in sub-address bits 6:3.
	localparam logic [3:0] REG_DATA = 4'h0;
	localparam logic [3:0] REG_DIV_LO = 4'h1;
	localparam logic [3:0] REG_DIV_HI = 4'h2;
	localparam logic [3:0] REG_MODE = 4'h3;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_EXTRA_FEATURE_CONTROL_REG = 4'hf;
	localparam int EXTRA_FEATURE_CONTROL_REG_AUTO_DIR = 4;
	localparam int EXTRA_FEATURE_CONTROL_REG_DIR_INV = 5;
	localparam int MODE_OVS_HI = 1;
	localparam int MODE_OVS_LO = 0;
	localparam int MODE_PRE4 = 2;
	localparam logic [1:0] OVS_SEL_8 = 2'h1;
	localparam logic [1:0] OVS_SEL_4 = 2'h2;
	localparam logic [4:0] OVS_16 = 5'h10;
	localparam logic [4:0] OVS_8 = 5'h08;
	localparam logic [4:0] OVS_4 = 5'h04;
	localparam logic [1:0] PRE_LIM_1 = 2'h0;
	localparam logic [1:0] PRE_LIM_4 = 2'h3;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] EXTRA_FEATURE_CONTROL_REG_RST = 8'h00;
	// Sub-address and SPI command byte fields.
	localparam int SUB_REG_HI = 6;
	localparam int SUB_REG_LO = 3;
	localparam int SUB_CH_HI = 2;
	localparam int SUB_CH_LO = 1;
	localparam int SPI_RD_BIT = 7;
	localparam logic [1:0] CH_VALID = 2'h0;
	// Slave address base (0x60 as an 8-bit write address).
	localparam logic [6:0] I2C_BASE = 7'h30;
	localparam logic [1:0] STRAP_GND = 2'h1;
	localparam logic [1:0] STRAP_SDA = 2'h3;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] SPI_LAST = 3'h7;
	localparam logic [3:0] FRAME_LAST = 4'h9;
	typedef enum {
		ST_IDLE, ST_ADDR, ST_SUB, ST_WR, ST_ACK, ST_RD, ST_RACK
	} uhp_i2c_st_t;
endpackage

// file: verification/tb_uart_host_port_rs485_dir.sv
// Bench for uhp_bridge: host traffic from the model, frames read off txd.
// Assumes the bridge is built with a 4-deep TX FIFO.
`timescale 1ns/100ps
module tb_uart_host_port_rs485_dir;
	localparam int DEPTH = 4;
	logic mclk = 1'b0;
	logic sys_rst, i2c_sel, rx_valid, inv, ack, sda, scl, m_sda, cs_n, si;
	logic sda_out, sda_oe_n, spi_so, spi_so_oe_n, txd, rts_n, rx_ready;
	logic [1:0] st_hi, st_lo;
	logic [7:0] rx_data, q, d, d_m, mode;
	logic [7:0] exp_q[$];
	int seed, n_errors = 0, samples_checked = 0, cyc = 0, bit_len = 256;
	assign sda = m_sda & (sda_oe_n | sda_out);
	always #4 mclk = ~mclk;
	uhp_bridge #(.FIFO_DEPTH(DEPTH)) dut (.mclk(mclk), .sys_rst(sys_rst),
		.clk_en(1'b1), .i2c_sel(i2c_sel), .addr_strap_hi(st_hi),
		.addr_strap_lo(st_lo), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .spi_cs_n(cs_n),
		.spi_si(si), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n),
		.txd(txd), .rts_n(rts_n), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready));
	uhp_host_model m (.mclk(mclk), .sda_in(sda), .so(spi_so), .scl(scl),
		.sda_m(m_sda), .cs_n(cs_n), .si(si));
	task automatic chk(input string what, input logic [7:0] e, s);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_errors++;
			test_done();
		end
	end
	function automatic logic [6:0] exp_addr(input logic [1:0] h, l);
		return {4'h6, h[0], l};
	endfunction
	function automatic int ratio(input logic [7:0] md);
		int o;
		o = (md[1:0] == 2'h1) ? 8 : (md[1:0] == 2'h2) ? 4 : 16;
		return md[2] ? 4 * o : o;
	endfunction
	task automatic open_w(input logic [3:0] r, input logic [1:0] ch,
		output logic ok);
		m.start();
		m.xfer({exp_addr(st_hi, st_lo), 1'b0}, q, ok);
		chk("address ack", 8'h01, 8'(ok));
		m.xfer({1'b0, r, ch, 1'b0}, q, ok);
	endtask
	task automatic wreg(input logic [3:0] r, input logic [7:0] v);
		open_w(r, 2'h0, ack);
		chk("sub ack", 8'h01, 8'(ack));
		m.xfer(v, q, ack);
		chk("data ack", 8'h01, 8'(ack));
		m.stop();
	endtask
	task automatic rreg(input logic [3:0] r, output logic [7:0] v);
		open_w(r, 2'h0, ack);
		m.stop();
		m.start();
		m.xfer({exp_addr(st_hi, st_lo), 1'b1}, q, ack);
		m.xfer(8'hff, v, ack);
		m.stop();
	endtask
	// Frames are sampled mid-bit from the falling edge of the start bit.
	always @(negedge txd) begin
		if (!sys_rst) begin
			repeat (bit_len / 2) @(posedge mclk);
			chk("start bit", 8'h00, 8'(txd));
			chk("frame dir", 8'(inv), 8'(rts_n));
			for (int i = 0; i < 8; i++) begin
				repeat (bit_len) @(posedge mclk);
				d_m[i] = txd;
			end
			repeat (bit_len) @(posedge mclk);
			chk("stop bit", 8'h01, 8'(txd));
			chk("stop dir", 8'(inv), 8'(rts_n));
			chk("frame", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx,
				d_m);
		end
	end
	initial begin
		seed = 32'hffe4;
		sys_rst = 1'b1;
		i2c_sel = 1'b1;
		inv = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		st_hi = 2'($random(seed));
		st_lo = 2'($random(seed));
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		chk("rts after reset", 8'h01, 8'(rts_n));
		m.start();
		m.xfer({exp_addr(st_hi, st_lo) ^ 7'h04, 1'b0}, q, ack);
		chk("foreign address", 8'h00, 8'(ack));
		m.stop();
		open_w(uhp_pkg::REG_EXTRA_FEATURE_CONTROL_REG, 2'h2, ack);
		chk("bad channel", 8'h00, 8'(ack));
		m.stop();
		// Fast-mode rate: about 312 mclk per scl period.
		m.H = 156;
		wreg(uhp_pkg::REG_DIV_HI, 8'h00);
		m.H = 6;
		for (int r = 0; r < 3; r++) begin
			mode = {5'h0, r[0], r[1:0]};
			inv = 1'($random(seed));
			wreg(uhp_pkg::REG_MODE, mode);
			wreg(uhp_pkg::REG_DIV_LO, 8'(256 / ratio(mode)));
			bit_len = ratio(mode) * (256 / ratio(mode));
			wreg(uhp_pkg::REG_EXTRA_FEATURE_CONTROL_REG, {2'h0, inv, 1'b1, 4'h0});
			chk("idle dir", 8'(!inv), 8'(rts_n));
			rreg(uhp_pkg::REG_STAT, q);
			chk("status", 8'h11, q);
			open_w(uhp_pkg::REG_DATA, 2'h0, ack);
			for (int i = 0; i < DEPTH + 2; i++) begin
				d = 8'($random(seed));
				m.xfer(d, q, ack);
				chk("burst ack", 8'(i <= DEPTH), 8'(ack));
				if (i <= DEPTH)
					exp_q.push_back(d);
			end
			m.stop();
			for (int i = 0; i < 20000 && exp_q.size() > 0; i++)
				@(posedge mclk);
			repeat (2 * bit_len) @(posedge mclk);
			chk("drained dir", 8'(!inv), 8'(rts_n));
			chk("frames left", 8'h00, 8'(exp_q.size()));
		end
		i2c_sel <= 1'b0;
		d = 8'($random(seed));
		@(posedge mclk);
		chk("rx space", 8'h01, 8'(rx_ready));
		rx_data <= d;
		rx_valid <= 1'b1;
		@(posedge mclk);
		rx_valid <= 1'b0;
		m.sel(1'b0);
		m.spi({1'b1, uhp_pkg::REG_DATA, 3'h0}, q);
		chk("so enable", 8'h00, 8'(spi_so_oe_n));
		m.spi(8'h00, q);
		m.sel(1'b1);
		chk("spi read", d, q);
		m.sel(1'b0);
		m.spi({1'b0, uhp_pkg::REG_EXTRA_FEATURE_CONTROL_REG, 3'h0}, q);
		m.spi(8'h00, q);
		m.sel(1'b1);
		chk("rts auto off", 8'h01, 8'(rts_n));
		test_done();
	end
endmodule // tb_uart_host_port_rs485_dir

// file: verification/uhp_checker.sv
// Pin-level assertions for uhp_bridge, attached by bind.
// Assumes one mclk domain and clk_en held high.
`timescale 1ns/100ps
module uhp_checker (
	input wire logic mclk, // Clock.
	input wire logic sys_rst, // Reset, high.
	input wire logic i2c_sel, // Host port select.
	input wire logic scl_in, // Serial clock.
	input wire logic sda_oe_n, // Data pull, low.
	input wire logic spi_cs_n, // SPI select, low.
	input wire logic spi_so_oe_n, // SO enable, low.
	input wire logic txd, // UART output.
	input wire logic rts_n, // Direction output.
	input wire logic rx_ready // RX FIFO space.
);
	logic so_off;
	assign so_off = i2c_sel | spi_cs_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_so_hiz: assert property (so_off && $past(so_off) &&
		$past(so_off, 2) |-> spi_so_oe_n) else $error("so driven");
	a_sda_spi_quiet: assert property (!i2c_sel && !$past(i2c_sel) &&
		!$past(i2c_sel, 2) |-> sda_oe_n) else $error("sda in spi");
	a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("ack starts with scl high");
	a_ack_hold: assert property (scl_in && $past(scl_in) |->
		$stable(sda_oe_n)) else $error("sda moved with scl high");
	a_rts_rst: assert property ($past(sys_rst) |-> rts_n)
		else $error("rts low after reset");
	a_idle_rst: assert property ($past(sys_rst) |->
		txd && rx_ready && spi_so_oe_n) else $error("outputs after reset");
	a_start_min: assert property ($fell(txd) |-> !txd [*4])
		else $error("start bit short");
	// The direction register lags the load by one edge, so wait two.
	a_rts_steady: assert property (!txd && !$past(txd) &&
		!$past(txd, 2) |-> $stable(rts_n)) else $error("rts moved in frame");
	c_ack: cover property ($fell(sda_oe_n));
	c_frame: cover property ($fell(txd));
	c_so: cover property ($fell(spi_so_oe_n));
endmodule // uhp_checker

bind uhp_bridge uhp_checker u_chk (.mclk(mclk), .sys_rst(sys_rst),
	.i2c_sel(i2c_sel), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
	.spi_cs_n(spi_cs_n), .spi_so_oe_n(spi_so_oe_n), .txd(txd),
	.rts_n(rts_n), .rx_ready(rx_ready));

// file: verification/uhp_host_model.sv
// Host model: an I2C or SPI master on the bridge's host pins.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/100ps
module uhp_host_model (
	input wire logic mclk, // Clock.
	input wire logic sda_in, // Resolved data line.
	input wire logic so, // SPI data from device.
	output logic scl, // Serial clock.
	output logic sda_m, // Data drive, 1 releases.
	output logic cs_n, // SPI select, low.
	output logic si // SPI data to device.
);
	// Half period of scl in mclk cycles; the bench may slow it down.
	int H = 6;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		cs_n = 1'b1;
		si = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Data moves only with scl low, so no false start or stop is seen.
	task automatic bit_io(input logic b, output logic r);
		w(2);
		sda_m <= b;
		w(H);
		scl <= 1'b1;
		w(H);
		r = sda_in;
		scl <= 1'b0;
	endtask
	task automatic start();
		w(2);
		sda_m <= 1'b1;
		w(H);
		scl <= 1'b1;
		w(H);
		sda_m <= 1'b0;
		w(H);
		scl <= 1'b0;
	endtask
	// Ninth bit released: ack for writes, nack ends a read.
	task automatic xfer(input logic [7:0] d, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic stop();
		w(2);
		sda_m <= 1'b0;
		w(H);
		scl <= 1'b1;
		w(H);
		sda_m <= 1'b1;
		w(H);
	endtask
	// A deselected SI line toggles so a stale value cannot pass.
	task automatic sel(input logic b);
		cs_n <= b;
		scl <= 1'b0;
		if (b)
			si <= ~si;
		w(H);
	endtask
	task automatic spi(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			si <= d[i];
			w(H);
			scl <= 1'b1;
			q[i] = so;
			w(H);
			scl <= 1'b0;
		end
	endtask
endmodule // uhp_host_model
